// ===== dv/fsil_host_model.sv
// host model on the register port of the framer status block
`timescale 1ns/100ps
module fsil_host_model
    import fsil_pkg::*;
(
    input wire logic clk,
    input wire logic stall,
    output logic [7:0] cpu_addr,
    output logic [7:0] cpu_wdata,
    output logic cpu_wr,
    output logic cpu_rd,
    input wire logic cpu_req_ready,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_rvalid,
    output logic cpu_rready
);
    assign cpu_rready = !stall;
    initial begin
        cpu_addr = 8'h00;
        cpu_wdata = 8'h00;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
    end
    task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        cpu_addr = a;
        cpu_wdata = (w && a == FSIL_ADDR_CTL_B) ? {1'b0, d[6:0]} : d;
        cpu_wr = w;
        cpu_rd = !w;
        // ready is settled between edges; the edge after a high ready takes the request
        for (int n = 0; n < 20 && cpu_req_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        // released lines flip so a stale value is never mistaken for a live one
        cpu_addr = ~a;
        cpu_wdata = ~d;
    endtask
    task automatic take(output logic [7:0] d);
        for (int n = 0; n < 20 && !(cpu_rvalid === 1'b1 && cpu_rready); n++) begin
            @(posedge clk);
            #1;
        end
        // data taken while it stands; the next edge pops it
        d = cpu_rdata;
        @(posedge clk);
        #1;
    endtask
    task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
        req(1'b1, a, m);
        req(1'b0, a, 8'h00);
        take(d);
        req(1'b1, a, d & m);
    endtask
    task automatic init();
        for (int i = 0; i < FSIL_NUM_MASK; i++) req(1'b1, FSIL_MASK_ADDR[i], 8'h00);
        req(1'b1, FSIL_ADDR_CTL_A, 8'h00);
        req(1'b1, FSIL_ADDR_CTL_B, 8'h00);
    endtask
endmodule // fsil_host_model

// ===== dv/testbench.sv
// self-checking bench for the framer status, interrupt and loopback block
`timescale 1ns/100ps
module testbench;
    import fsil_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic stall = 1'b0;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, d, e;
    logic cpu_wr, cpu_rd, cpu_req_ready, cpu_rvalid, cpu_rready, int_n, pout_a, pout_b;
    logic [1:0] rx = 2'b10, fmt = 2'b01, tx_a, tx_b, rxo_a, rxo_b;
    logic [4:0] ch = 5'h00;
    logic [3:0] uop;
    logic [103:0] live = '0;
    int num_errors = 0;
    int total_checks = 0;
    // row: control byte, user pins, line pins, payload at channel 12 and 13
    logic [15:0] rows [0:3] = '{16'h4558, 16'h3aa7, 16'h700b, 16'h2005};
    always #50 clk = ~clk;
    fsil_framer_status_irq u_dut (.clk(clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_req_ready(cpu_req_ready), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .cpu_rready(cpu_rready), .line_rx_positive_in(rx[1]),
        .line_rx_negative_in(rx[0]), .fmt_a_tx_pos(fmt[1]), .fmt_a_tx_neg(fmt[0]),
        .line_tx_positive_out(tx_a[1]), .line_tx_negative_out(tx_a[0]), .rx_a_pos_out(rxo_a[1]),
        .rx_a_neg_out(rxo_a[0]), .framer_b_rx_positive_in(rx[0]), .framer_b_rx_negative_in(rx[1]),
        .fmt_b_tx_pos(fmt[0]), .fmt_b_tx_neg(fmt[1]), .framer_b_tx_positive_out(tx_b[0]),
        .framer_b_tx_negative_out(tx_b[1]), .rx_b_pos_out(rxo_b[0]), .rx_b_neg_out(rxo_b[1]),
        .tx_a_payload_in(1'b0), .tx_a_channel(ch), .tx_a_payload_out(pout_a), .tx_b_payload_in(1'b0),
        .tx_b_channel(ch), .tx_b_payload_out(pout_b), .user_output_bit0(uop[0]), .user_output_bit1(uop[1]),
        .user_output_bit2(uop[2]), .user_output_bit3(uop[3]), .status_live(live), .int_n(int_n));
    fsil_host_model u_host (.clk(clk), .stall(stall), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_req_ready(cpu_req_ready), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .cpu_rready(cpu_rready));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        // about 150 cycles are needed; twenty times that means a hang
        #(3000 * 100);
        num_errors++;
        $display("ERROR watchdog expired");
        finish_test();
    end
    initial begin
        step(5);
        chk("ready_in_reset", cpu_req_ready, 8'h00);
        chk("int_in_reset", int_n, 8'h01);
        sys_rst = 1'b0;
        u_host.init();
        foreach (rows[i]) begin
            u_host.req(1'b1, FSIL_ADDR_CTL_A, rows[i][15:8]);
            u_host.req(1'b1, FSIL_ADDR_CTL_B, rows[i][15:8]);
            u_host.req(1'b0, FSIL_ADDR_CTL_B, 8'h00);
            u_host.take(d);
            chk("ctl_b", d, rows[i][15:8]);
            ch = 5'h0c;
            step(2);
            chk("user_pins", uop, rows[i][7:4]);
            chk("line_a", tx_a, rows[i][3:2]);
            chk("line_b", tx_b, rows[i][3:2]);
            chk("rx_a", rxo_a, rx);
            chk("rx_b", rxo_b, rx);
            chk("ais_lo", {pout_a, pout_b}, {2{rows[i][1]}});
            ch = 5'h0d;
            step(2);
            chk("ais_up", {pout_a, pout_b}, {2{rows[i][0]}});
        end
        u_host.req(1'b1, 8'h16, 8'h01);
        u_host.req(1'b1, 8'h17, 8'h0c);
        u_host.req(1'b1, 8'h51, 8'h01);
        live[48] = 1'b1;
        step(1);
        live[48] = 1'b0;
        live[0] = 1'b1;
        step(3);
        chk("alarm_on", int_n, 8'h00);
        u_host.poll(8'h20, 8'h01, d);
        chk("alarm_read", d, 8'h01);
        step(3);
        chk("alarm_held_rel", int_n, 8'h01);
        live[0] = 1'b0;
        step(3);
        chk("alarm_off", int_n, 8'h00);
        u_host.poll(8'h20, 8'h01, d);
        live[10] = 1'b1;
        live[96] = 1'b1;
        step(1);
        live[10] = 1'b0;
        live[96] = 1'b0;
        step(3);
        chk("event_on", int_n, 8'h00);
        u_host.poll(8'h21, 8'h04, d);
        chk("event_read", d, 8'h04);
        step(3);
        chk("other_pending", int_n, 8'h00);
        live[11] = 1'b1;
        step(1);
        live[11] = 1'b0;
        u_host.req(1'b1, 8'h21, 8'h00);
        u_host.req(1'b0, 8'h21, 8'h00);
        u_host.take(d);
        chk("hold_on_zero", d, 8'h00);
        u_host.poll(8'h21, 8'h08, d);
        chk("refresh_on_one", d, 8'h08);
        u_host.poll(8'h50, 8'h01, d);
        chk("tester_read", d, 8'h01);
        u_host.poll(8'h21, 8'h0c, d);
        chk("cleared", d, 8'h00);
        step(3);
        chk("all_clear", int_n, 8'h01);
        u_host.req(1'b0, 8'h03, 8'h00);
        u_host.take(d);
        chk("unmapped", d, 8'h00);
        stall = 1'b1;
        u_host.req(1'b0, FSIL_ADDR_CTL_B, 8'h00);
        u_host.req(1'b0, FSIL_ADDR_CTL_A, 8'h00);
        step(1);
        chk("buffer_full", cpu_req_ready, 8'h00);
        stall = 1'b0;
        u_host.take(d);
        u_host.take(e);
        chk("drain_b", d, 8'h20);
        chk("drain_a", e, 8'h20);
        finish_test();
    end
endmodule // testbench

// ===== rtl/fsil_framer_status_irq.sv
// top of the framer status, interrupt, loopback and channel alarm block
`timescale 1ns/100ps
module fsil_framer_status_irq
    import fsil_pkg::*;
#(
    parameter int NUM_STAT = FSIL_NUM_STAT,
    parameter int NUM_MASK = FSIL_NUM_MASK
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic cpu_req_ready,
    output logic [7:0] cpu_rdata,
    output logic cpu_rvalid,
    input wire logic cpu_rready,
    input wire logic line_rx_positive_in,
    input wire logic line_rx_negative_in,
    input wire logic fmt_a_tx_pos,
    input wire logic fmt_a_tx_neg,
    output logic line_tx_positive_out,
    output logic line_tx_negative_out,
    output logic rx_a_pos_out,
    output logic rx_a_neg_out,
    input wire logic framer_b_rx_positive_in,
    input wire logic framer_b_rx_negative_in,
    input wire logic fmt_b_tx_pos,
    input wire logic fmt_b_tx_neg,
    output logic framer_b_tx_positive_out,
    output logic framer_b_tx_negative_out,
    output logic rx_b_pos_out,
    output logic rx_b_neg_out,
    input wire logic tx_a_payload_in,
    input wire logic [4:0] tx_a_channel,
    output logic tx_a_payload_out,
    input wire logic tx_b_payload_in,
    input wire logic [4:0] tx_b_channel,
    output logic tx_b_payload_out,
    output logic user_output_bit0,
    output logic user_output_bit1,
    output logic user_output_bit2,
    output logic user_output_bit3,
    input wire logic [NUM_STAT*8-1:0] status_live,
    output logic int_n
);
    // control registers
    logic [7:0] framer_a_control_seven_reg, framer_a_control_seven_next;
    logic [7:0] framer_b_control_seven_reg, framer_b_control_seven_next;
    logic [7:0] mask_reg [0:NUM_MASK-1];
    logic [7:0] mask_next [0:NUM_MASK-1];

    // host access decode
    logic wr_take, rd_take, buf_in_ready;
    logic [NUM_STAT-1:0] stat_hit, stat_irq;
    logic [7:0] stat_read [0:NUM_STAT-1];
    logic [7:0] rd_mux;

    // line, payload, pin and interrupt flops
    logic line_tx_pos_reg, line_tx_pos_next, line_tx_neg_reg, line_tx_neg_next;
    logic b_tx_pos_reg, b_tx_pos_next, b_tx_neg_reg, b_tx_neg_next;
    logic rx_a_pos_reg, rx_a_neg_reg, rx_b_pos_reg, rx_b_neg_reg;
    logic pay_a_reg, pay_a_next, pay_b_reg, pay_b_next;
    logic [3:0] uop_reg, uop_next;
    logic int_n_reg, int_n_next;

    // reads and writes both wait on the buffer ready; only a read is pushed into it
    assign wr_take = cpu_wr & buf_in_ready;
    assign rd_take = cpu_rd & ~cpu_wr & buf_in_ready;

    function automatic logic ais_hit(input logic [4:0] ch, input logic [7:0] ctl);
        logic lower;
        logic upper;
        lower = (ch >= FSIL_CH_FIRST) && (ch <= FSIL_CH_SPLIT);
        upper = (ch > FSIL_CH_SPLIT) && (ch <= FSIL_CH_LAST);
        return (upper && ctl[FSIL_BIT_AIS_UP]) || (lower && ctl[FSIL_BIT_AIS_LO]);
    endfunction

    // control register writes
    always_comb begin
        framer_a_control_seven_next = framer_a_control_seven_reg;
        framer_b_control_seven_next = framer_b_control_seven_reg;
        if (wr_take && cpu_addr == FSIL_ADDR_CTL_A) begin
            framer_a_control_seven_next = cpu_wdata;
        end
        if (wr_take && cpu_addr == FSIL_ADDR_CTL_B) begin
            // top bit kept as written; host is expected to write it as zero
            framer_b_control_seven_next = cpu_wdata;
        end
        for (int m = 0; m < NUM_MASK; m++) begin
            mask_next[m] = mask_reg[m];
            if (wr_take && cpu_addr == FSIL_MASK_ADDR[m]) begin
                mask_next[m] = cpu_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            framer_a_control_seven_reg <= FSIL_CTL_RESET;
            framer_b_control_seven_reg <= FSIL_CTL_RESET;
            for (int m = 0; m < NUM_MASK; m++) begin
                mask_reg[m] <= FSIL_MASK_RESET;
            end
        end else begin
            framer_a_control_seven_reg <= framer_a_control_seven_next;
            framer_b_control_seven_reg <= framer_b_control_seven_next;
            for (int m = 0; m < NUM_MASK; m++) begin
                mask_reg[m] <= mask_next[m];
            end
        end
    end

    // status and information registers, six per framer plus pattern tester
    for (genvar g = 0; g < NUM_STAT; g++) begin : g_stat
        logic [7:0] eff_mask;
        assign stat_hit[g] = (cpu_addr == FSIL_STAT_ADDR[g]); // R8
        if (FSIL_STAT_MASK_IDX[g] == FSIL_NO_MASK) begin : g_nomask
            // receive information registers never reach the interrupt
            assign eff_mask = 8'h00;
        end else begin : g_mask
            assign eff_mask = mask_reg[FSIL_STAT_MASK_IDX[g]]; // R14
        end
        fsil_status_cell #(
            .W(8),
            .ALARM_BITS(FSIL_STAT_ALARM[g])
        ) u_cell (
            .clk(clk),
            .sys_rst(sys_rst),
            .live(status_live[g*8 +: 8]),
            .wr(wr_take & stat_hit[g]),
            .rd(rd_take & stat_hit[g]),
            .wdata(cpu_wdata),
            .irq_mask(eff_mask),
            .read_q(stat_read[g]),
            .irq(stat_irq[g])
        );
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_mux = 8'h00;
        if (cpu_addr == FSIL_ADDR_CTL_A) begin
            rd_mux = framer_a_control_seven_reg;
        end
        if (cpu_addr == FSIL_ADDR_CTL_B) begin
            rd_mux = framer_b_control_seven_reg;
        end
        for (int m = 0; m < NUM_MASK; m++) begin
            if (cpu_addr == FSIL_MASK_ADDR[m]) begin
                rd_mux = mask_reg[m];
            end
        end
        for (int s = 0; s < NUM_STAT; s++) begin
            if (stat_hit[s]) begin
                rd_mux = stat_read[s];
            end
        end
    end

    // a stalled reader loses no read answer; reads clear bits, so none may drop
    fsil_pair_buf #(
        .W(8)
    ) u_rd_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(rd_mux),
        .in_valid(rd_take),
        .in_ready(buf_in_ready),
        .out_data(cpu_rdata),
        .out_valid(cpu_rvalid),
        .out_ready(cpu_rready)
    );
    assign cpu_req_ready = buf_in_ready;

    // line loopbacks, alarm insertion, user pins and interrupt
    always_comb begin
        line_tx_pos_next = fmt_a_tx_pos;
        line_tx_neg_next = fmt_a_tx_neg;
        if (framer_a_control_seven_reg[FSIL_BIT_LOOP]) begin
            line_tx_pos_next = line_rx_positive_in; // R3 R4
            line_tx_neg_next = line_rx_negative_in; // R3 R4
        end
        b_tx_pos_next = fmt_b_tx_pos;
        b_tx_neg_next = fmt_b_tx_neg;
        if (framer_b_control_seven_reg[FSIL_BIT_LOOP]) begin
            b_tx_pos_next = framer_b_rx_positive_in; // R1 R2
            b_tx_neg_next = framer_b_rx_negative_in; // R1 R2
        end
        pay_a_next = ais_hit(tx_a_channel, framer_a_control_seven_reg) ? FSIL_AIS_LEVEL : tx_a_payload_in;
        pay_b_next = ais_hit(tx_b_channel, framer_b_control_seven_reg) ? FSIL_AIS_LEVEL : tx_b_payload_in; // R5
        uop_next = framer_b_control_seven_reg[FSIL_BIT_USER_OUTPUT_BIT3:FSIL_BIT_USER_OUTPUT_BIT0]; // R6
        int_n_next = ~(|stat_irq); // R18
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            line_tx_pos_reg <= 1'b0;
            line_tx_neg_reg <= 1'b0;
            b_tx_pos_reg <= 1'b0;
            b_tx_neg_reg <= 1'b0;
            rx_a_pos_reg <= 1'b0;
            rx_a_neg_reg <= 1'b0;
            rx_b_pos_reg <= 1'b0;
            rx_b_neg_reg <= 1'b0;
            pay_a_reg <= 1'b0;
            pay_b_reg <= 1'b0;
            uop_reg <= 4'h0;
            int_n_reg <= 1'b1;
        end else begin
            line_tx_pos_reg <= line_tx_pos_next;
            line_tx_neg_reg <= line_tx_neg_next;
            b_tx_pos_reg <= b_tx_pos_next;
            b_tx_neg_reg <= b_tx_neg_next;
            // receive paths always see the line, loopback or not
            rx_a_pos_reg <= line_rx_positive_in; // R4
            rx_a_neg_reg <= line_rx_negative_in; // R4
            rx_b_pos_reg <= framer_b_rx_positive_in; // R2
            rx_b_neg_reg <= framer_b_rx_negative_in; // R2
            pay_a_reg <= pay_a_next;
            pay_b_reg <= pay_b_next;
            uop_reg <= uop_next;
            int_n_reg <= int_n_next;
        end
    end

    assign line_tx_positive_out = line_tx_pos_reg;
    assign line_tx_negative_out = line_tx_neg_reg;
    assign framer_b_tx_positive_out = b_tx_pos_reg;
    assign framer_b_tx_negative_out = b_tx_neg_reg;
    assign rx_a_pos_out = rx_a_pos_reg;
    assign rx_a_neg_out = rx_a_neg_reg;
    assign rx_b_pos_out = rx_b_pos_reg;
    assign rx_b_neg_out = rx_b_neg_reg;
    assign tx_a_payload_out = pay_a_reg;
    assign tx_b_payload_out = pay_b_reg;
    assign user_output_bit0 = uop_reg[0];
    assign user_output_bit1 = uop_reg[1];
    assign user_output_bit2 = uop_reg[2];
    assign user_output_bit3 = uop_reg[3];
    assign int_n = int_n_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_ctl_b_write;
        wr_take && cpu_addr == FSIL_ADDR_CTL_B;
    endsequence

    AST_BACKEND_LOOPBACK_ENABLE_ROUTE: assert property (framer_b_control_seven_reg[FSIL_BIT_LOOP] |=> // R1
        (framer_b_tx_positive_out == $past(framer_b_rx_positive_in)
        && framer_b_tx_negative_out == $past(framer_b_rx_negative_in)))
        else $error("back end loopback not routed");
    AST_BACKEND_LOOPBACK_ENABLE_RX_KEEP: assert property (framer_b_control_seven_reg[FSIL_BIT_LOOP] |=> // R2
        (rx_b_pos_out == $past(framer_b_rx_positive_in) && rx_b_neg_out == $past(framer_b_rx_negative_in)))
        else $error("framer B receive path lost during loopback");
    AST_RLB_ROUTE: assert property (framer_a_control_seven_reg[FSIL_BIT_LOOP] |=> // R3
        (line_tx_positive_out == $past(line_rx_positive_in)
        && line_tx_negative_out == $past(line_rx_negative_in)))
        else $error("remote loopback not routed");
    AST_RLB_RX_KEEP: assert property (framer_a_control_seven_reg[FSIL_BIT_LOOP] |=> // R4
        (rx_a_pos_out == $past(line_rx_positive_in) && rx_a_neg_out == $past(line_rx_negative_in)))
        else $error("framer A receive path lost during loopback");
    AST_NO_LOOP_B: assert property (!framer_b_control_seven_reg[FSIL_BIT_LOOP] |=> // R1
        (framer_b_tx_positive_out == $past(fmt_b_tx_pos)))
        else $error("formatter B output not sent without loopback");
    AST_AIS_UPPER: assert property (framer_b_control_seven_reg[FSIL_BIT_AIS_UP] // R5
        && tx_b_channel > FSIL_CH_SPLIT && tx_b_channel <= FSIL_CH_LAST |=> tx_b_payload_out == FSIL_AIS_LEVEL)
        else $error("alarm not inserted in upper channels");
    AST_AIS_PASS: assert property (!framer_b_control_seven_reg[FSIL_BIT_AIS_UP] // R5
        && !framer_b_control_seven_reg[FSIL_BIT_AIS_LO] |=> tx_b_payload_out == $past(tx_b_payload_in))
        else $error("payload altered without alarm insertion");
    AST_UOP_PIN: assert property (s_ctl_b_write |-> ##2 // R6
        ({user_output_bit3, user_output_bit2, user_output_bit1, user_output_bit0} == $past(cpu_wdata[3:0], 2)))
        else $error("user pins do not follow control write");
    AST_INT_LOW: assert property (|stat_irq |=> !int_n) // R18
        else $error("pending source did not hold interrupt low");
    AST_INT_HIGH: assert property (stat_irq == '0 |=> int_n) // R18
        else $error("interrupt low with nothing pending");
endmodule // fsil_framer_status_irq

// ===== rtl/fsil_pair_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module fsil_pair_buf #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] slot0_reg, slot0_next, slot1_reg, slot1_next;
    logic [1:0] cnt_reg, cnt_next;
    logic ready_reg, valid_reg, push, pop;

    always_comb begin
        push = in_valid & ready_reg;
        pop = valid_reg & out_ready;
        slot0_next = slot0_reg;
        slot1_next = slot1_reg;
        cnt_next = cnt_reg;
        case ({push, pop})
            2'b10: begin
                if (cnt_reg == 2'd0) slot0_next = in_data;
                else slot1_next = in_data;
                cnt_next = cnt_reg + 2'd1;
            end
            2'b01: begin
                slot0_next = slot1_reg;
                cnt_next = cnt_reg - 2'd1;
            end
            2'b11: begin
                if (cnt_reg == 2'd1) slot0_next = in_data;
                else begin
                    slot0_next = slot1_reg;
                    slot1_next = in_data;
                end
            end
            default: cnt_next = cnt_reg;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slot0_reg <= '0;
            slot1_reg <= '0;
            cnt_reg <= 2'd0;
            ready_reg <= 1'b0;
            valid_reg <= 1'b0;
        end else begin
            slot0_reg <= slot0_next;
            slot1_reg <= slot1_next;
            cnt_reg <= cnt_next;
            ready_reg <= (cnt_next != 2'd2);
            valid_reg <= (cnt_next != 2'd0);
        end
    end

    assign in_ready = ready_reg;
    assign out_valid = valid_reg;
    assign out_data = slot0_reg;
endmodule // fsil_pair_buf

// ===== rtl/fsil_pkg.sv
// constants shared by the framer status, interrupt and loopback block
// Overview of operation
// R1: backend_loopback_enable set sends framer B receive line pins to its transmit pins.
// R2: in backend loopback, framer B receive still works; its formatter output is dropped.
// R3: remote_loopback_enable set sends line receive pins back to line transmit pins.
// R4: in remote loopback, framer A receive still works; its formatter output is ignored.
// R5: two control bits insert all-ones alarm in channels 13-24 and 1-12 respectively.
// R6: each of four user output bits drives its own pin to the stored level.
// R7: host writes zero to the unassigned top bit of framer_b_control_seven.
// R8: each framer has nine status registers; a bit sets when its event occurs; the code has six status and information registers per framer.
// R9: status and receive information bits latch and stay set until the host reads them.
// R10: a read clears a latched bit; alarm bits stay set while the alarm persists.
// R11: writing 1 to a status bit refreshes its readable value and selects it for clearing.
// R12: writing 0 to a status bit keeps its previously captured readable value.
// R13: host polls with mask write, immediate read, then writes back read ANDed with mask.
// R14: status, link controller and pattern tester bits reach the interrupt through mask bits.
// R15: an unmasked alarm drives the interrupt low on every change of state.
// R16: reading the responsible alarm bit releases its interrupt even while alarm persists.
// R17: an unmasked event drives the interrupt low until the host reads that bit.
// R18: the interrupt returns high only when no unmasked source is still pending.
// R19: after power-up the host writes every register, test registers included, to defined values; init writes only the mask and control registers.
package fsil_pkg;
    localparam int FSIL_DW = 8;
    localparam int FSIL_CH_W = 5;
    localparam int FSIL_NUM_STAT = 13;
    localparam int FSIL_NUM_MASK = 7;
    localparam int FSIL_NO_MASK = 7;
    localparam logic [7:0] FSIL_ADDR_CTL_A = 8'h0a;
    localparam logic [7:0] FSIL_ADDR_CTL_B = 8'haa;
    localparam logic [7:0] FSIL_CTL_RESET = 8'h00;
    localparam logic [7:0] FSIL_MASK_RESET = 8'h00;
    localparam int FSIL_BIT_LOOP = 6;
    localparam int FSIL_BIT_AIS_UP = 5;
    localparam int FSIL_BIT_AIS_LO = 4;
    localparam int FSIL_BIT_USER_OUTPUT_BIT3 = 3;
    localparam int FSIL_BIT_USER_OUTPUT_BIT2 = 2;
    localparam int FSIL_BIT_USER_OUTPUT_BIT1 = 1;
    localparam int FSIL_BIT_USER_OUTPUT_BIT0 = 0;
    localparam logic [4:0] FSIL_CH_FIRST = 5'h01;
    localparam logic [4:0] FSIL_CH_SPLIT = 5'h0c;
    localparam logic [4:0] FSIL_CH_LAST = 5'h18;
    localparam logic FSIL_AIS_LEVEL = 1'b1;
    // order: sr1a sr2a rir1a rir2a rir3a sr1b sr2b rir1b rir2b rir3b lnka lnkb pat
    localparam logic [7:0] FSIL_STAT_ADDR [0:12] = '{8'h20, 8'h21, 8'h22, 8'h31, 8'h10,
        8'hc0, 8'hc1, 8'hc2, 8'hd1, 8'hb0, 8'h40, 8'he0, 8'h50};
    localparam logic [7:0] FSIL_STAT_ALARM [0:12] = '{8'h0f, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam int FSIL_STAT_MASK_IDX [0:12] = '{0, 1, 7, 7, 7, 2, 3, 7, 7, 7, 4, 5, 6};
    // order: irq_mask_one a/two a, one b/two b, link ctl a/b, pattern tester
    localparam logic [7:0] FSIL_MASK_ADDR [0:6] = '{8'h16, 8'h17, 8'hb6, 8'hb7, 8'h41, 8'he1, 8'h51};
endpackage

// ===== rtl/fsil_status_cell.sv
// one latched status register with write-read-write clearing and its interrupt term
`timescale 1ns/100ps
module fsil_status_cell #(
    parameter int W = 8,
    parameter logic [W-1:0] ALARM_BITS = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] live,
    input wire logic wr,
    input wire logic rd,
    input wire logic [W-1:0] wdata,
    input wire logic [W-1:0] irq_mask,
    output logic [W-1:0] read_q,
    output logic irq
);
    logic [W-1:0] live_q_reg, latch_reg, latch_next, read_reg, read_next, sel_reg, sel_next;
    logic [W-1:0] change_reg, change_next, chg_cap_reg, chg_cap_next, live_edge, rd_clr, chg_clr;
    logic irq_reg, irq_next;

    always_comb begin
        live_edge = (live ^ live_q_reg) & ALARM_BITS;
        // only bits actually shown as 1 are cleared, so a later event survives
        rd_clr = rd ? (sel_reg & read_reg) : '0;
        chg_clr = rd ? chg_cap_reg : '0;
        latch_next = (latch_reg & ~rd_clr) | live; // R9 R10
        change_next = (change_reg & ~chg_clr) | live_edge; // R15 R16
        read_next = read_reg;
        sel_next = rd ? '0 : sel_reg;
        chg_cap_next = rd ? '0 : chg_cap_reg;
        if (wr) begin
            read_next = (read_reg & ~wdata) | ((latch_reg | live) & wdata); // R11 R12
            sel_next = wdata; // R11
            chg_cap_next = change_reg & wdata;
        end
        irq_next = |(((latch_next & ~ALARM_BITS) | change_next) & irq_mask); // R14 R17
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            live_q_reg <= '0;
            latch_reg <= '0;
            read_reg <= '0;
            sel_reg <= '0;
            change_reg <= '0;
            chg_cap_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            live_q_reg <= live;
            latch_reg <= latch_next;
            read_reg <= read_next;
            sel_reg <= sel_next;
            change_reg <= change_next;
            chg_cap_reg <= chg_cap_next;
            irq_reg <= irq_next;
        end
    end

    assign read_q = read_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_alarm_on;
        (|(live & ALARM_BITS)) [*2];
    endsequence
    AST_LATCH_SET: assert property (|live |=> ((latch_reg & $past(live)) == $past(live))) // R9
        else $error("live status bit did not latch");
    AST_ALARM_HOLD: assert property (s_alarm_on |-> // R10
        ((latch_reg & live & $past(live) & ALARM_BITS) == (live & $past(live) & ALARM_BITS)))
        else $error("alarm bit dropped while alarm present");
    AST_WR_UPDATE: assert property (wr |=> ((read_reg & $past(wdata)) == (($past(latch_reg) | $past(live)) & $past(wdata)))) // R11
        else $error("selected bit not refreshed on write");
    AST_WR_HOLD: assert property (wr |=> ((read_reg & ~$past(wdata)) == ($past(read_reg) & ~$past(wdata)))) // R12
        else $error("unselected bit changed on write");
    AST_ALARM_IRQ: assert property (|(live_edge & irq_mask) |=> irq) // R15
        else $error("alarm change raised no interrupt");
    AST_EVENT_IRQ: assert property (|(live & ~ALARM_BITS & irq_mask) |=> irq ##1 irq) // R17
        else $error("event raised no interrupt");
    AST_ALARM_RELEASE: assert property (rd && change_reg == chg_cap_reg && live_edge == '0
        && (latch_reg & ~ALARM_BITS & ~(sel_reg & read_reg)) == '0 && (live & ~ALARM_BITS) == '0 |=> !irq) // R16
        else $error("interrupt not released by read");
endmodule // fsil_status_cell
